//--- root_cfg_map.svh
// Register offsets, fields, reset values and timing counts for root-port config access
`ifndef ROOT_CFG_MAP_SVH
`define ROOT_CFG_MAP_SVH
`define OFF_COMMAND 12'h000
`define OFF_REQ_ID 12'h004
`define OFF_BUS_NUMS 12'h008
`define OFF_BAR_CTRL 12'h00c
`define OFF_BAR_BASE 12'h010
`define OFF_TRANS_BASE 12'h014
`define OFF_IRQ_STATUS 12'h018
`define OFF_IRQ_MASK 12'h01c
`define OFF_SELF_DATA 12'h020
`define BIT_MASTER_EN 2
`define BIT_BAR_EN 0
`define BIT_XLATE_EN 1
`define BIT_IRQ_TIMEOUT 0
`define BIT_IRQ_BADBUS 1
`define BIT_IRQ_UR 2
`define BIT_IRQ_PWRLIM 3
`define IRQ_WIDTH 4
`define BAR_BASE_RESET 32'h0000_0000
`define ECAM_BIT 28
`define CFG_TIMEOUT_DEFAULT 5000
`endif

//--- root_cfg_pkg.sv
// Types for root-port config access
package root_cfg_pkg;
  typedef enum logic [1:0] {cpl_sc_type, cpl_ur_type, cpl_other_type} cpl_status_type;
  typedef enum logic [1:0] {cfg_none_type, cfg_type0_type, cfg_type1_type} cfg_kind_type;
  typedef enum {st_idle, st_decode, st_link, st_resp} cfg_state_type;
endpackage : root_cfg_pkg

//--- root_link_partner.sv
// Far side of the link: takes config requests, answers them promptly or late, or never in silent mode
`timescale 1ns/1ns
`default_nettype none
module root_link_partner (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] mode,
  input wire logic cfg_req_valid,
  input wire logic [27:0] cfg_req_addr,
  output logic cfg_req_ready,
  output logic cfg_cpl_valid,
  output logic [1:0] cfg_cpl_status,
  output logic [31:0] cfg_cpl_data,
  output logic pwr_msg_ready
);
  logic [27:0] addr_q;
  logic [2:0] dly;
  logic pend;
  wire logic hs = cfg_req_valid && cfg_req_ready;
  wire logic done = pend && dly == 3'h0 && !hs;
  always @(posedge aclk) begin
    if (!aresetn) begin
      pend <= 1'h0;
      cfg_req_ready <= 1'h0;
      cfg_cpl_valid <= 1'h0;
      cfg_cpl_data <= 32'h0;
      cfg_cpl_status <= 2'h0;
      pwr_msg_ready <= 1'h0;
    end else begin
      pwr_msg_ready <= 1'($urandom_range(1));
      cfg_req_ready <= cfg_req_valid && !cfg_req_ready && !pend && 1'($urandom_range(1));
      cfg_cpl_valid <= done;
      // Idle completion lines toggle so stale data never looks valid
      cfg_cpl_status <= done ? mode : ~cfg_cpl_status;
      cfg_cpl_data <= done ? {4'h0, addr_q} ^ 32'h5a5a_0000 : ~cfg_cpl_data;
      if (hs) begin
        addr_q <= cfg_req_addr;
        pend <= mode != 2'h2; // Silent mode never completes
        dly <= 3'($urandom_range(5));
      end else if (pend && dly != 3'h0) begin
        dly <= dly - 3'h1;
      end else begin
        pend <= 1'h0;
      end
    end
  end
endmodule : root_link_partner
`default_nettype wire

//--- root_port_config_access.sv
// Root-port configuration access, power limit message and BAR forwarding
// Behaviour
// - Send power limit message on master-enable set
// - Primary bus access configures self only
// - Secondary bus access becomes type 0
// - Above secondary to subordinate becomes type 1
// - Out-of-range bus answers SLVERR, no request
// - Read with UR returns all ones
// - Write with UR answers SLVERR
// - BAR never filters, translation per configuration
// - No BAR: pass packets unchanged
// - BAR base resets zero, hits translated
// - Timed-out config request answers SLVERR
// - Timeout also raises interrupt
//
// Local design decisions: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "root_cfg_map.svh"
module root_port_config_access #(
  parameter int unsigned cfg_timeout_cycles = `CFG_TIMEOUT_DEFAULT
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ctl_awvalid,
  output logic ctl_awready,
  input wire logic [31:0] ctl_awaddr,
  input wire logic ctl_wvalid,
  output logic ctl_wready,
  input wire logic [31:0] ctl_wdata,
  input wire logic [3:0] ctl_wstrb,
  output logic ctl_bvalid,
  input wire logic ctl_bready,
  output logic [1:0] ctl_bresp,
  input wire logic ctl_arvalid,
  output logic ctl_arready,
  input wire logic [31:0] ctl_araddr,
  output logic ctl_rvalid,
  input wire logic ctl_rready,
  output logic [31:0] ctl_rdata,
  output logic [1:0] ctl_rresp,
  output logic cfg_req_valid,
  input wire logic cfg_req_ready,
  output logic cfg_req_type1,
  output logic cfg_req_write,
  output logic [27:0] cfg_req_addr,
  output logic [31:0] cfg_req_data,
  output logic [15:0] cfg_req_id,
  input wire logic cfg_cpl_valid,
  input wire logic [1:0] cfg_cpl_status,
  input wire logic [31:0] cfg_cpl_data,
  output logic pwr_msg_valid,
  input wire logic pwr_msg_ready,
  output logic [15:0] pwr_msg_req_id,
  input wire logic rx_valid,
  input wire logic [63:0] rx_addr,
  input wire logic [31:0] rx_data,
  output logic fwd_valid,
  output logic [63:0] fwd_addr,
  output logic [31:0] fwd_data,
  output logic irq
);
  logic [31:0] command;
  logic [15:0] req_id;
  logic [7:0] bus_primary, bus_secondary, bus_subordinate;
  logic bar_en, xlate_en;
  logic [31:0] bar_base, trans_base;
  logic [`IRQ_WIDTH-1:0] irq_status, irq_mask, irq_set;
  logic [31:0] self_data [0:255];
  root_cfg_pkg::cfg_state_type state;
  logic busy_write;
  logic [27:0] ecam_addr;
  logic [31:0] ecam_wdata;
  logic [31:0] tmo_count;
  logic aw_held, w_held;
  logic [31:0] aw_addr_q, w_data_q;
  logic [7:0] tbus;
  logic reg_wr, reg_rd, ecam_wr, ecam_rd;
  logic [31:0] reg_rdata;
  logic reg_hit;
  logic [11:0] reg_off;
  logic in_range;
  logic bar_hit;
  // Register-window writes complete at once; ECAM ones go through the engine
  assign reg_wr = aw_held && w_held && !ctl_bvalid && state == root_cfg_pkg::st_idle
    && !aw_addr_q[`ECAM_BIT];
  assign ecam_wr = aw_held && w_held && !ctl_bvalid && state == root_cfg_pkg::st_idle
    && aw_addr_q[`ECAM_BIT];
  assign reg_rd = ctl_arvalid && ctl_arready && !ctl_araddr[`ECAM_BIT];
  assign ecam_rd = ctl_arvalid && ctl_arready && ctl_araddr[`ECAM_BIT] && !ecam_wr;
  assign reg_off = reg_wr ? aw_addr_q[11:0] : ctl_araddr[11:0];
  assign tbus = ecam_addr[27:20];
  assign in_range = tbus >= bus_secondary && tbus <= bus_subordinate;
  always_comb begin
    reg_hit = 1'b1;
    case ({reg_off[11:2], 2'b00})
      `OFF_COMMAND: reg_rdata = command;
      `OFF_REQ_ID: reg_rdata = {16'h0000, req_id};
      `OFF_BUS_NUMS: reg_rdata = {8'h00, bus_subordinate, bus_secondary, bus_primary};
      `OFF_BAR_CTRL: reg_rdata = {30'h0000_0000, xlate_en, bar_en};
      `OFF_BAR_BASE: reg_rdata = bar_base;
      `OFF_TRANS_BASE: reg_rdata = trans_base;
      `OFF_IRQ_STATUS: reg_rdata = {28'h000_0000, irq_status};
      `OFF_IRQ_MASK: reg_rdata = {28'h000_0000, irq_mask};
      default: begin
        reg_rdata = 32'h0000_0000;
        reg_hit = 1'b0;
      end
    endcase
  end
  // Address and data channels accepted in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= 32'h0000_0000;
      w_data_q <= 32'h0000_0000;
    end else begin
      if (ctl_awvalid && ctl_awready) begin
        aw_held <= 1'b1;
        aw_addr_q <= ctl_awaddr;
      end else if (reg_wr || ecam_wr) begin
        aw_held <= 1'b0;
      end
      if (ctl_wvalid && ctl_wready) begin
        w_held <= 1'b1;
        w_data_q <= ctl_wdata;
      end else if (reg_wr || ecam_wr) begin
        w_held <= 1'b0;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_awready <= 1'b0;
      ctl_wready <= 1'b0;
      ctl_arready <= 1'b0;
    end else begin
      ctl_awready <= !aw_held && !(ctl_awvalid && ctl_awready);
      ctl_wready <= !w_held && !(ctl_wvalid && ctl_wready);
      // Reads wait while a write owns the engine or a read answer is pending
      ctl_arready <= !ctl_arready && !ctl_rvalid && state == root_cfg_pkg::st_idle
        && !(aw_held && w_held);
    end
  end
  // Control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      command <= 32'h0000_0000;
      req_id <= 16'h0000;
      bus_primary <= 8'h00;
      bus_secondary <= 8'h00;
      bus_subordinate <= 8'h00;
      bar_en <= 1'b0;
      xlate_en <= 1'b0;
      bar_base <= `BAR_BASE_RESET;
      trans_base <= 32'h0000_0000;
      irq_mask <= '0;
    end else if (reg_wr && ctl_wstrb == 4'hf) begin
      case ({aw_addr_q[11:2], 2'b00})
        `OFF_COMMAND: command <= w_data_q;
        `OFF_REQ_ID: req_id <= w_data_q[15:0];
        `OFF_BUS_NUMS: {bus_subordinate, bus_secondary, bus_primary} <= w_data_q[23:0];
        `OFF_BAR_CTRL: {xlate_en, bar_en} <= w_data_q[1:0];
        `OFF_BAR_BASE: bar_base <= w_data_q;
        `OFF_TRANS_BASE: trans_base <= w_data_q;
        `OFF_IRQ_MASK: irq_mask <= w_data_q[`IRQ_WIDTH-1:0];
        default: ;
      endcase
    end
  end
  // Power limit message on the rising edge of master enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr_msg_valid <= 1'b0;
      pwr_msg_req_id <= 16'h0000;
    end else if (reg_wr && {aw_addr_q[11:2], 2'b00} == `OFF_COMMAND
        && w_data_q[`BIT_MASTER_EN] && !command[`BIT_MASTER_EN]) begin
      pwr_msg_valid <= 1'b1;
      pwr_msg_req_id <= req_id;
    end else if (pwr_msg_ready) begin
      pwr_msg_valid <= 1'b0;
    end
  end
  // Config engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= root_cfg_pkg::st_idle;
      busy_write <= 1'b0;
      ecam_addr <= 28'h000_0000;
      ecam_wdata <= 32'h0000_0000;
      tmo_count <= 32'h0000_0000;
      cfg_req_valid <= 1'b0;
      cfg_req_type1 <= 1'b0;
      cfg_req_write <= 1'b0;
      cfg_req_addr <= 28'h000_0000;
      cfg_req_data <= 32'h0000_0000;
      cfg_req_id <= 16'h0000;
      ctl_bvalid <= 1'b0;
      ctl_bresp <= 2'b00;
      ctl_rvalid <= 1'b0;
      ctl_rdata <= 32'h0000_0000;
      ctl_rresp <= 2'b00;
      irq_set <= '0;
    end else begin
      irq_set <= '0;
      if (ctl_bvalid && ctl_bready) ctl_bvalid <= 1'b0;
      if (ctl_rvalid && ctl_rready) ctl_rvalid <= 1'b0;
      if (reg_wr) begin
        ctl_bvalid <= 1'b1;
        ctl_bresp <= reg_hit ? 2'b00 : 2'b10;
      end
      if (reg_rd) begin
        ctl_rvalid <= 1'b1;
        ctl_rdata <= reg_rdata;
        ctl_rresp <= reg_hit ? 2'b00 : 2'b10;
      end
      case (state)
        root_cfg_pkg::st_idle: begin
          if (ecam_wr) begin
            state <= root_cfg_pkg::st_decode;
            busy_write <= 1'b1;
            ecam_addr <= aw_addr_q[27:0];
            ecam_wdata <= w_data_q;
          end else if (ecam_rd) begin
            state <= root_cfg_pkg::st_decode;
            busy_write <= 1'b0;
            ecam_addr <= ctl_araddr[27:0];
          end
        end
        root_cfg_pkg::st_decode: begin
          state <= root_cfg_pkg::st_idle;
          if (tbus == bus_primary) begin
            // Self access never reaches the link
            if (busy_write) begin
              ctl_bvalid <= 1'b1;
              ctl_bresp <= 2'b00;
            end else begin
              ctl_rvalid <= 1'b1;
              ctl_rdata <= self_data[ecam_addr[9:2]];
              ctl_rresp <= 2'b00;
            end
          end else if (in_range) begin
            state <= root_cfg_pkg::st_link;
            tmo_count <= 32'h0000_0000;
            cfg_req_valid <= 1'b1;
            cfg_req_type1 <= tbus != bus_secondary;
            cfg_req_write <= busy_write;
            cfg_req_addr <= ecam_addr;
            cfg_req_data <= ecam_wdata;
            cfg_req_id <= req_id;
          end else begin
            irq_set[`BIT_IRQ_BADBUS] <= 1'b1;
            if (busy_write) begin
              ctl_bvalid <= 1'b1;
              ctl_bresp <= 2'b10;
            end else begin
              ctl_rvalid <= 1'b1;
              ctl_rdata <= 32'h0000_0000;
              ctl_rresp <= 2'b10;
            end
          end
        end
        root_cfg_pkg::st_link: begin
          if (cfg_req_valid && cfg_req_ready) cfg_req_valid <= 1'b0;
          tmo_count <= tmo_count + 32'h0000_0001;
          if (cfg_cpl_valid && !cfg_req_valid) begin
            state <= root_cfg_pkg::st_idle;
            if (cfg_cpl_status == 2'(root_cfg_pkg::cpl_ur_type)) irq_set[`BIT_IRQ_UR] <= 1'b1;
            if (busy_write) begin
              ctl_bvalid <= 1'b1;
              ctl_bresp <= cfg_cpl_status == 2'(root_cfg_pkg::cpl_sc_type) ? 2'b00 : 2'b10;
            end else begin
              ctl_rvalid <= 1'b1;
              if (cfg_cpl_status == 2'(root_cfg_pkg::cpl_ur_type)) begin
                ctl_rdata <= 32'hffff_ffff;
                ctl_rresp <= 2'b00;
              end else begin
                ctl_rdata <= cfg_cpl_data;
                ctl_rresp <= cfg_cpl_status == 2'(root_cfg_pkg::cpl_sc_type) ? 2'b00 : 2'b10;
              end
            end
          end else if (tmo_count >= cfg_timeout_cycles - 1) begin
            // Request withdrawn so a late completion cannot be mistaken for a new one
            state <= root_cfg_pkg::st_idle;
            cfg_req_valid <= 1'b0;
            irq_set[`BIT_IRQ_TIMEOUT] <= 1'b1;
            if (busy_write) begin
              ctl_bvalid <= 1'b1;
              ctl_bresp <= 2'b10;
            end else begin
              ctl_rvalid <= 1'b1;
              ctl_rdata <= 32'h0000_0000;
              ctl_rresp <= 2'b10;
            end
          end
        end
        default: state <= root_cfg_pkg::st_idle;
      endcase
      if (pwr_msg_valid && pwr_msg_ready) irq_set[`BIT_IRQ_PWRLIM] <= 1'b1;
    end
  end
  // Self configuration space
  always_ff @(posedge aclk) begin
    if (state == root_cfg_pkg::st_decode && busy_write && tbus == bus_primary) begin
      self_data[ecam_addr[9:2]] <= ecam_wdata;
    end
  end
  // Sticky status, set wins over write-one-to-clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~((reg_wr && {aw_addr_q[11:2], 2'b00} == `OFF_IRQ_STATUS)
        ? w_data_q[`IRQ_WIDTH-1:0] : '0)) | irq_set;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) irq <= 1'b0;
    else irq <= |(irq_status & irq_mask);
  end
  // Inbound forwarding: nothing filtered, translation only on BAR hit
  assign bar_hit = bar_en && rx_addr[63:32] == 32'h0000_0000 && rx_addr[31:16] == bar_base[31:16];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fwd_valid <= 1'b0;
      fwd_addr <= 64'h0000_0000_0000_0000;
      fwd_data <= 32'h0000_0000;
    end else begin
      fwd_valid <= rx_valid;
      fwd_data <= rx_data;
      if (bar_hit && xlate_en) begin
        fwd_addr <= {32'h0000_0000, trans_base[31:16], rx_addr[15:0]};
      end else begin
        fwd_addr <= rx_addr;
      end
    end
  end
endmodule : root_port_config_access
`default_nettype wire

//--- root_port_config_access_monitor.sv
// Checker of config routing, completions, timeout and forwarding at the block ports
`timescale 1ns/1ns
`default_nettype none
`include "root_cfg_map.svh"
module root_port_config_access_monitor #(
  parameter int unsigned cfg_timeout_cycles = 20
) (
  input wire logic aclk, aresetn, ctl_awvalid, ctl_awready, ctl_wvalid, ctl_wready,
  input wire logic ctl_bvalid, ctl_bready, ctl_arvalid, ctl_arready, ctl_rvalid, ctl_rready,
  input wire logic [31:0] ctl_awaddr, ctl_wdata, ctl_araddr, ctl_rdata, rx_data, fwd_data,
  input wire logic [1:0] ctl_bresp, ctl_rresp, cfg_cpl_status,
  input wire logic cfg_req_valid, cfg_req_type1, cfg_cpl_valid, rx_valid, fwd_valid,
  input wire logic pwr_msg_valid, pwr_msg_ready,
  input wire logic [15:0] pwr_msg_req_id,
  input wire logic [27:0] cfg_req_addr
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [31:0] aw_q, w_q, buses;
  logic rd_pend;
  logic [15:0] lk_cnt;
  wire logic [7:0] bus = cfg_req_addr[27:20];
  always_ff @(posedge aclk) begin
    if (ctl_awvalid && ctl_awready) aw_q <= ctl_awaddr;
    if (ctl_wvalid && ctl_wready) w_q <= ctl_wdata;
  end
  // Shadow follows only accepted writes, so a refused one cannot skew it
  always_ff @(posedge aclk) begin
    if (!aresetn) buses <= 32'h0;
    else if (ctl_bvalid && ctl_bready && ctl_bresp == 2'h0 && aw_q == 32'(`OFF_BUS_NUMS))
      buses <= w_q;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) rd_pend <= 1'h0;
    else if (ctl_arvalid && ctl_arready) rd_pend <= 1'h1;
    else if (ctl_rvalid && ctl_rready) rd_pend <= 1'h0;
  end
  // Age of a link request until the bus is answered
  always_ff @(posedge aclk) begin
    if (!aresetn || ctl_bvalid || ctl_rvalid) lk_cnt <= 16'h0;
    else if (cfg_req_valid || lk_cnt != 16'h0) lk_cnt <= lk_cnt + 16'h1;
  end
  property p_type0; cfg_req_valid && bus == buses[15:8] |-> !cfg_req_type1; endproperty
  a_type0: assert property (p_type0) else $error("secondary bus not type 0");
  property p_type1; cfg_req_valid && bus > buses[15:8] |-> cfg_req_type1; endproperty
  a_type1: assert property (p_type1) else $error("deeper bus not type 1");
  property p_self; cfg_req_valid |-> bus != buses[7:0]; endproperty
  a_self: assert property (p_self) else $error("primary bus seen on link");
  property p_range; cfg_req_valid |-> bus >= buses[15:8] && bus <= buses[23:16]; endproperty
  a_range: assert property (p_range) else $error("request outside bus range");
  property p_badbus;
    ctl_arvalid && ctl_arready && ctl_araddr[28] && ctl_araddr[27:20] > buses[23:16]
      |-> ##[1:6] (ctl_rvalid && ctl_rresp == 2'h2);
  endproperty
  a_badbus: assert property (p_badbus) else $error("bad bus read not refused");
  property p_ur_read;
    cfg_cpl_valid && cfg_cpl_status == 2'h1 && rd_pend
      |=> ctl_rvalid && ctl_rresp == 2'h0 && ctl_rdata == 32'hffff_ffff;
  endproperty
  a_ur_read: assert property (p_ur_read) else $error("absent device read wrong");
  property p_ur_write;
    cfg_cpl_valid && cfg_cpl_status == 2'h1 && !rd_pend |-> ##[1:3] (ctl_bvalid && ctl_bresp == 2'h2);
  endproperty
  a_ur_write: assert property (p_ur_write) else $error("absent device write ok");
  property p_timeout; lk_cnt <= 16'(cfg_timeout_cycles + 8); endproperty
  a_timeout: assert property (p_timeout) else $error("link request never ended");
  property p_fwd; rx_valid |=> fwd_valid && fwd_data == $past(rx_data); endproperty
  a_fwd: assert property (p_fwd) else $error("received packet dropped");
  property p_pwr; pwr_msg_valid && !pwr_msg_ready |=> pwr_msg_valid && $stable(pwr_msg_req_id);
  endproperty
  a_pwr: assert property (p_pwr) else $error("power message withdrawn");
endmodule : root_port_config_access_monitor
bind root_port_config_access root_port_config_access_monitor #(
  .cfg_timeout_cycles(cfg_timeout_cycles)) u_mon (.*);
`default_nettype wire

//--- tb_root_port_config_access.sv
// Self-checking bench for root-port config access
`timescale 1ns/1ns
`default_nettype none
`include "root_cfg_map.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module tb_root_port_config_access;
  logic aclk = 1'h0, aresetn = 1'h0, ctl_awvalid = 1'h0, ctl_wvalid = 1'h0;
  logic ctl_bready = 1'h0, ctl_arvalid = 1'h0, ctl_rready = 1'h0, rx_valid = 1'h0;
  logic [31:0] ctl_awaddr = 32'h0, ctl_wdata = 32'h0, ctl_araddr = 32'h0, rx_data = 32'h0;
  logic [3:0] ctl_wstrb = 4'hf;
  logic [63:0] rx_addr = 64'h0, fwd_addr, ra;
  logic [1:0] mode = 2'h0, ctl_bresp, ctl_rresp, cfg_cpl_status;
  logic ctl_awready, ctl_wready, ctl_bvalid, ctl_arready, ctl_rvalid, cfg_req_valid, w;
  logic cfg_req_ready, cfg_req_type1, cfg_req_write, cfg_cpl_valid, pwr_msg_valid;
  logic pwr_msg_ready, fwd_valid, irq;
  logic [31:0] ctl_rdata, cfg_req_data, cfg_cpl_data, fwd_data, rdat;
  logic [27:0] cfg_req_addr;
  logic [15:0] cfg_req_id, pwr_msg_req_id, rid;
  int n_errors = 0, checks_done = 0;
  logic [34:0] exp_a[$];
  logic [28:0] exp_q[$];
  logic [95:0] exp_f[$];
  logic [15:0] exp_m[$];
  root_port_config_access #(.cfg_timeout_cycles(20)) dut (.*);
  root_link_partner link (.*);
  initial forever #50 aclk = ~aclk;
  task automatic give_verdict();
    if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  // One access at a time; expected {check data, resp, data} noted first
  task automatic acc(input logic w, input logic [31:0] a, d, input logic [1:0] r, input logic c);
    @(posedge aclk);
    exp_a.push_back({c, r, d});
    ctl_awvalid <= w;
    ctl_wvalid <= w;
    ctl_arvalid <= !w;
    ctl_awaddr <= a;
    ctl_araddr <= a;
    ctl_wdata <= d;
    ctl_bready <= w;
    ctl_rready <= !w;
    do begin
      @(posedge aclk);
      if (ctl_awready) ctl_awvalid <= 1'h0;
      if (ctl_wready) ctl_wvalid <= 1'h0;
      if (ctl_arready) ctl_arvalid <= 1'h0;
    end while (!(ctl_bvalid && ctl_bready || ctl_rvalid && ctl_rready));
    ctl_bready <= 1'h0;
    ctl_rready <= 1'h0;
  endtask : acc
  task automatic lk(input logic w, input logic [7:0] b, input logic [31:0] d,
                    input logic [1:0] r, input logic c, input logic m);
    logic [31:0] a;
    a = {4'h1, b, 20'($urandom) & 20'hffffc};
    if (b >= 8'h01 && b <= 8'h05) exp_q.push_back({b > 8'h01, a[27:0]});
    acc(w, a, m ? d ^ {4'h0, a[27:0]} : d, r, c);
  endtask : lk
  always @(posedge aclk) begin
    if (ctl_bvalid && ctl_bready || ctl_rvalid && ctl_rready) begin
      `CHK(ctl_bvalid ? ctl_bresp : ctl_rresp, exp_a[0][33:32])
      if (exp_a[0][34]) `CHK(ctl_rdata, exp_a[0][31:0])
      void'(exp_a.pop_front());
    end
    if (cfg_req_valid && cfg_req_ready) `CHK({cfg_req_type1, cfg_req_addr}, exp_q.pop_front())
    if (pwr_msg_valid && pwr_msg_ready) `CHK(pwr_msg_req_id, exp_m.pop_front())
    if (fwd_valid) `CHK({fwd_addr, fwd_data}, exp_f.pop_front())
  end
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    give_verdict();
  end
  initial begin
    void'($urandom(27));
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    acc(1'h0, `OFF_BAR_BASE, `BAR_BASE_RESET, 2'h0, 1'h1);
    acc(1'h0, 32'h0000_0ffc, 32'h0, 2'h2, 1'h1);
    rid = 16'($urandom);
    acc(1'h1, `OFF_REQ_ID, {16'h0, rid}, 2'h0, 1'h0);
    acc(1'h1, `OFF_BUS_NUMS, 32'h0005_0100, 2'h0, 1'h0);
    acc(1'h1, `OFF_IRQ_MASK, 32'hf, 2'h0, 1'h0);
    exp_m.push_back(rid);
    acc(1'h1, `OFF_COMMAND, 32'h4, 2'h0, 1'h0);
    // Bus 0 primary, 1 secondary, 2..5 below, 6 and 7 beyond subordinate
    for (int b = 0; b < 8; b++) begin
      w = b > 5 ? 1'(b) : 1'($urandom);
      lk(w, 8'(b), w ? $urandom : 32'h5a5a_0000, b > 5 ? 2'h2 : 2'h0, !w && b > 0 && b < 6,
         1'h1);
    end
    mode <= 2'h1;
    lk(1'h0, 8'h03, 32'hffff_ffff, 2'h0, 1'h1, 1'h0);
    lk(1'h1, 8'h01, 32'h1234_5678, 2'h2, 1'h0, 1'h0);
    mode <= 2'h2;
    lk(1'h0, 8'h04, 32'h0, 2'h2, 1'h0, 1'h0);
    acc(1'h0, `OFF_IRQ_STATUS, 32'hf, 2'h0, 1'h1);
    `CHK(irq, 1'h1)
    for (int i = 0; i < 3; i++) begin
      acc(1'h1, i == 2 ? `OFF_IRQ_STATUS : `OFF_IRQ_MASK, i == 0 ? 32'h0 : 32'hf, 2'h0, 1'h0);
      repeat (3) @(posedge aclk);
      `CHK(irq, 1'(i == 1))
    end
    for (int i = 0; i < 6; i++) begin
      @(posedge aclk);
      ra = {$urandom, $urandom};
      rdat = $urandom;
      exp_f.push_back({ra, rdat});
      rx_valid <= 1'h1;
      rx_addr <= ra;
      rx_data <= rdat;
    end
    @(posedge aclk);
    rx_valid <= 1'h0;
    repeat (4) @(posedge aclk);
    acc(1'h1, `OFF_BAR_BASE, 32'h1234_0000, 2'h0, 1'h0);
    acc(1'h1, `OFF_TRANS_BASE, 32'habcd_0000, 2'h0, 1'h0);
    acc(1'h1, `OFF_BAR_CTRL, 32'h3, 2'h0, 1'h0);
    // Partner keeps to the window while the BAR is on
    for (int i = 0; i < 4; i++) begin
      @(posedge aclk);
      ra = {32'h0, 16'h1234, 16'($urandom)};
      rdat = $urandom;
      exp_f.push_back({32'h0, 16'habcd, ra[15:0], rdat});
      rx_valid <= 1'h1;
      rx_addr <= ra;
      rx_data <= rdat;
    end
    @(posedge aclk);
    rx_valid <= 1'h0;
    repeat (4) @(posedge aclk);
    `CHK(exp_a.size() + exp_q.size() + exp_f.size() + exp_m.size(), 0)
    give_verdict();
  end
endmodule : tb_root_port_config_access
`default_nettype wire
